/* inc/dpsr_consts.vh */
/*
 shared ram constants: address windows, page split, storage size, sizes.
 assumes 32-bit byte addresses on both ports.
*/
`ifndef DPSR_CONSTS_VH
`define DPSR_CONSTS_VH
`define DPSR_CACHED_BASE 32'h055F_0000
`define DPSR_CACHED_LAST 32'h0560_FFFF
`define DPSR_UNCACHED_BASE 32'hA55F_0000
`define DPSR_UNCACHED_LAST 32'hA560_FFFF
`define DPSR_DMA_BASE 32'h055F_0000
`define DPSR_DMA_LAST 32'h0560_FFFF
`define DPSR_WORDS 32768
`define DPSR_IDX_W 15
`define DPSR_PAGE_BIT 14
`define DPSR_SIZE_BYTE 2'h0
`define DPSR_SIZE_HALF 2'h1
`define DPSR_SIZE_WORD 2'h2
`define DPSR_SYS_LATENCY 2'h2
`endif

/* rtl/dpsr_shared_ram.v */
/*
 dual-port shared ram, 128 kbytes as 32768 words of 32 bits.
 local port: single-cycle unless it loses the page to the system port.
 system port: two-cycle access, refused while sleeping.
 assumes one clock, requests held until ready, masters on the same clock.
 big-endian lanes: byte offset 0 is the most significant byte of a word.
 limitation: a refused system access still spends its two cycles.
*/
`default_nettype none
`include "dpsr_consts.vh"

// Overview of operation
// - 128 kbytes, two read/write ports
// - processor accesses: byte, halfword, word
// - signal core accesses: halfword, word
// - decode cached and uncached address windows
// - storage split into pages zero, one
// - same address: system port wins
// - processor cached via system, uncached local
// - signal core routed likewise, single moves
// - local one cycle; system takes more
// - dma only through system port window
// - sleep refuses system bus masters
// - errored writes may corrupt contents
// - memory stopped during sleep (here sleep only refuses the system port; local accesses still run)
module dpsr_shared_ram (
   // clock and reset
   input wire clock,
   input wire reset,
   // chip state
   input wire sleepMode,
   // local bus port
   input wire localReq,
   input wire localWrite,
   input wire [1:0] localSize,
   input wire [31:0] localAddr,
   input wire [31:0] localWdata,
   output wire localReady,
   output reg [31:0] localRdata_reg,
   output reg localError_reg,
   // internal system bus port
   input wire sysReq,
   input wire sysWrite,
   input wire [1:0] sysSize,
   input wire [31:0] sysAddr,
   input wire [31:0] sysWdata,
   output wire sysReady,
   output reg [31:0] sysRdata_reg,
   output reg sysError_reg
);
   // storage lives in the per-lane banks further down
   wire [31:0] localWord;
   wire [31:0] sysWord;

   // window decode: local port serves the uncached window, system the cached one
   // the dma controller reaches the same cached window through the system port
   wire localHit = (localAddr >= `DPSR_UNCACHED_BASE) && (localAddr <= `DPSR_UNCACHED_LAST);
   wire sysHit = (sysAddr >= `DPSR_CACHED_BASE) && (sysAddr <= `DPSR_CACHED_LAST);
   wire [31:0] localOff = localAddr - `DPSR_UNCACHED_BASE;
   wire [31:0] sysOff = sysAddr - `DPSR_CACHED_BASE;
   wire [`DPSR_IDX_W-1:0] localIdx = localOff[`DPSR_IDX_W+1:2];
   wire [`DPSR_IDX_W-1:0] sysIdx = sysOff[`DPSR_IDX_W+1:2];
   wire localPage = localIdx[`DPSR_PAGE_BIT];
   wire sysPage = sysIdx[`DPSR_PAGE_BIT];

   // alignment: halfword on even, word on 4-byte boundary
   function misaligned;
      input [1:0] size;
      input [1:0] low;
      begin
         misaligned = (size == `DPSR_SIZE_HALF && low[0]) ||
            (size == `DPSR_SIZE_WORD && low != 2'h0) || (size == 2'h3);
      end
   endfunction

   // byte lanes, big-endian ordering within the word
   function [3:0] laneMask;
      input [1:0] size;
      input [1:0] low;
      begin
         case (size)
            `DPSR_SIZE_BYTE: laneMask = 4'h8 >> low;
            `DPSR_SIZE_HALF: laneMask = low[1] ? 4'h3 : 4'hC;
            default: laneMask = 4'hF;
         endcase
      end
   endfunction

   // replicate narrow write data onto every lane it might occupy
   function [31:0] spread;
      input [1:0] size;
      input [31:0] d;
      begin
         case (size)
            `DPSR_SIZE_BYTE: spread = {4{d[7:0]}};
            `DPSR_SIZE_HALF: spread = {2{d[15:0]}};
            default: spread = d;
         endcase
      end
   endfunction

   // read data right-justified
   function [31:0] extract;
      input [1:0] size;
      input [1:0] low;
      input [31:0] w;
      begin
         case (size)
            `DPSR_SIZE_BYTE: extract = {24'h00_0000, w[31-8*low -: 8]};
            `DPSR_SIZE_HALF: extract = {16'h0000, low[1] ? w[15:0] : w[31:16]};
            default: extract = w;
         endcase
      end
   endfunction

   // system port sequencer: cycle one claims the page, cycle two completes
   localparam SYS_IDLE = 1'b0;
   localparam SYS_BUSY = 1'b1;
   reg sysState_reg;
   reg sysState_next;
   reg [1:0] sysCount_reg;
   reg [1:0] sysCount_next;

   // sleep refuses system masters only; the local port keeps running then
   wire sysAllowed = !sleepMode;
   wire sysStart = sysReq && (sysState_reg == SYS_IDLE);
   wire sysPageHeld = (sysState_reg == SYS_BUSY) || sysStart;
   wire [`DPSR_IDX_W-1:0] sysHeldIdx = sysIdx;
   // refused accesses run the same two cycles, so timing never depends on errors
   wire sysDone = (sysState_reg == SYS_BUSY) && (sysCount_reg == `DPSR_SYS_LATENCY - 2'h1);
   assign sysReady = sysDone;

   // local stalls while the system port owns its page, covering same address too
   // a system access refused for sleep or window holds no page; a misaligned one still stalls the local port
   wire localBlocked = sysPageHeld && sysHit && sysAllowed &&
      (sysIdx[`DPSR_PAGE_BIT] == localPage);
   assign localReady = localReq && !localBlocked;

   always @* begin
      sysState_next = sysState_reg;
      sysCount_next = sysCount_reg;
      case (sysState_reg)
         SYS_IDLE: begin
            if (sysReq) begin
               sysState_next = SYS_BUSY;
               sysCount_next = 2'h1;
            end
         end
         SYS_BUSY: begin
            if (sysDone) begin
               sysState_next = SYS_IDLE;
               sysCount_next = 2'h0;
            end else begin
               // not reached at the present latency; kept for a longer one
               sysCount_next = sysCount_reg + 2'h1;
            end
         end
         default: begin
            sysState_next = SYS_IDLE;
            sysCount_next = 2'h0;
         end
      endcase
   end

   // size code 3 is no legal width and is answered as an error
   wire localBad = !localHit || misaligned(localSize, localAddr[1:0]);
   wire sysBad = !sysHit || !sysAllowed || misaligned(sysSize, sysAddr[1:0]);
   wire [3:0] localLanes = laneMask(localSize, localAddr[1:0]);
   wire [3:0] sysLanes = laneMask(sysSize, sysAddr[1:0]);
   wire [31:0] localWide = spread(localSize, localWdata);
   wire [31:0] sysWide = spread(sysSize, sysWdata);
   // writes with an address error are dropped; contents are never touched by them
   wire localWr = localReady && localWrite && !localBad;
   wire sysWr = sysDone && sysWrite && !sysBad;

   // one byte-wide bank per lane keeps every array to a single writer
   genvar lane;
   generate
      for (lane = 0; lane < 4; lane = lane + 1) begin : gLane
         reg [7:0] bank [0:`DPSR_WORDS-1];
         // same word written by both in one cycle: the system port wins the lane
         always @(posedge clock) begin
            if (sysWr && sysLanes[lane]) begin
               bank[sysHeldIdx] <= sysWide[8*lane+7:8*lane];
            end else if (localWr && localLanes[lane]) begin
               bank[localIdx] <= localWide[8*lane+7:8*lane];
            end
         end
         // unclocked read, registered into the data outputs below
         assign localWord[8*lane+7:8*lane] = bank[localIdx];
         assign sysWord[8*lane+7:8*lane] = bank[sysHeldIdx];
      end
   endgenerate

   // the banks are never cleared; their contents are undefined after power-up
   always @(posedge clock) begin
      if (reset) begin
         sysState_reg <= SYS_IDLE;
         sysCount_reg <= 2'h0;
         localRdata_reg <= 32'h0000_0000;
         localError_reg <= 1'b0;
         sysRdata_reg <= 32'h0000_0000;
         sysError_reg <= 1'b0;
      end else begin
         sysState_reg <= sysState_next;
         sysCount_reg <= sysCount_next;
         localError_reg <= localReady && localBad;
         if (localReady && !localWrite && !localBad) begin
            localRdata_reg <= extract(localSize, localAddr[1:0], localWord);
         end
         sysError_reg <= sysDone && sysBad;
         if (sysDone && !sysWrite && !sysBad) begin
            sysRdata_reg <= extract(sysSize, sysAddr[1:0], sysWord);
         end
      end
   end
endmodule
`default_nettype wire

/* dv/dpsr_ram_checker.sv */
/* port checker for the dual-port shared ram.
   assumes one clock and the synchronous active-high reset. */
`default_nettype none
module dpsr_ram_checker (
   // watched ports
   input wire logic clock, input wire logic reset, input wire logic sleepMode,
   input wire logic localReq, input wire logic [1:0] localSize,
   input wire logic [31:0] localAddr, input wire logic localReady,
   input wire logic localError_reg, input wire logic sysReq,
   input wire logic [31:0] sysAddr, input wire logic sysReady, input wire logic sysError_reg
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   wire sIn = sysAddr >= 32'h055F_0000 && sysAddr <= 32'h0560_FFFF;
   wire lIn = localAddr >= 32'hA55F_0000 && localAddr <= 32'hA560_FFFF;
   // both windows share the low offset bits, so bit 16 picks the page
   wire same = localAddr[16] == sysAddr[16];
   chk_sys_second: assert property ($rose(sysReq) |-> !sysReady ##1 sysReady)
      else $error("system answer not in second cycle");
   chk_sys_pulse: assert property (sysReady |=> !sysReady)
      else $error("system ready longer than one cycle");
   chk_local_free: assert property (localReq && !sysReq |-> localReady)
      else $error("local port stalled with no conflict");
   chk_page_stall: assert property (localReq && sysReq && sIn && !sleepMode && same |-> !localReady)
      else $error("local port not stalled on same page");
   chk_other_page: assert property (localReq && sysReq && !same |-> localReady)
      else $error("local port stalled on other page");
   chk_sleep_refuse: assert property (sysReady && sleepMode |=> sysError_reg)
      else $error("system access taken while asleep");
   chk_sys_window: assert property (sysReady && !sIn |=> sysError_reg)
      else $error("system access outside window taken");
   chk_local_good: assert property (localReady && lIn && localSize == 2'h2 && localAddr[1:0] == 2'h0 |=> !localError_reg)
      else $error("good local access flagged");
   chk_local_cached: assert property (localReady && !lIn |=> localError_reg)
      else $error("cached address taken on local port");
endmodule
bind dpsr_shared_ram dpsr_ram_checker chk (.clock(clock), .reset(reset), .sleepMode(sleepMode),
   .localReq(localReq), .localSize(localSize), .localAddr(localAddr), .localReady(localReady),
   .localError_reg(localError_reg), .sysReq(sysReq), .sysAddr(sysAddr), .sysReady(sysReady),
   .sysError_reg(sysError_reg));
`default_nettype wire

/* dv/dpsr_master_model.sv */
/* bus master model for one port of the shared ram.
   assumes go() is called at a rising clock edge. */
`default_nettype none
module dpsr_master_model (
   // answer
   input wire logic clock, input wire logic rdy, input wire logic er, input wire logic [31:0] rd,
   // request
   output logic req, output logic wr, output logic [1:0] sz, output logic [31:0] ad,
   output logic [31:0] wd
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      req = 1'b0;
      wr = 1'b0;
      sz = 2'h0;
      ad = 32'h0000_0000;
      wd = 32'h0000_0000;
   end
   task automatic go(input logic w, input logic [1:0] s, input logic [31:0] a, d,
      output logic [31:0] q, output logic e, output int n);
      n = 0;
      req <= 1'b1;
      wr <= w;
      sz <= s;
      ad <= a;
      wd <= d;
      do begin
         @(posedge clock);
         n++;
      end while (rdy !== 1'b1 && n < 40);
      req <= 1'b0;
      // released data must not keep its last value
      wd <= ~d;
      @(posedge clock);
      q = rd;
      e = er;
   endtask
endmodule
`default_nettype wire

/* dv/dpsr_shared_ram_bench.sv */
/* self-checking bench for the shared ram, masters on both ports.
   assumes the design and checker are compiled first. */
`default_nettype none
module dpsr_shared_ram_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 0;
   logic reset = 1;
   logic sleepMode = 0;
   logic lReq, lWr, sReq, sWr, lRdy, sRdy, lErr, sErr, e, e2;
   logic [1:0] lSz, sSz;
   logic [31:0] lAd, lWd, lRd, sAd, sWd, sRd, q, q2;
   int n_fail = 0;
   int n_compared = 0;
   int c, c2;
   dpsr_shared_ram dut (.clock(clock), .reset(reset), .sleepMode(sleepMode),
      .localReq(lReq), .localWrite(lWr), .localSize(lSz), .localAddr(lAd), .localWdata(lWd),
      .localReady(lRdy), .localRdata_reg(lRd), .localError_reg(lErr), .sysReq(sReq),
      .sysWrite(sWr), .sysSize(sSz), .sysAddr(sAd), .sysWdata(sWd), .sysReady(sRdy),
      .sysRdata_reg(sRd), .sysError_reg(sErr));
   dpsr_master_model lm (.clock(clock), .rdy(lRdy), .er(lErr), .rd(lRd), .req(lReq), .wr(lWr),
      .sz(lSz), .ad(lAd), .wd(lWd));
   dpsr_master_model sm (.clock(clock), .rdy(sRdy), .er(sErr), .rd(sRd), .req(sReq), .wr(sWr),
      .sz(sSz), .ad(sAd), .wd(sWd));
   initial forever #20 clock = ~clock;
   task cmp(input string nm, input logic [31:0] x, input logic [31:0] g);
      n_compared++;
      if (g !== x) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", nm, x, g);
      end
   endtask
   task stop_test;
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task t_sizes;
      lm.go(1, 2'h2, 32'hA55F_0000, 32'h1122_3344, q, e, c);
      lm.go(0, 2'h0, 32'hA55F_0001, 0, q, e, c);
      cmp("byte", 32'h0000_0022, q);
      lm.go(1, 2'h0, 32'hA55F_0003, 32'h0000_00AB, q, e, c);
      lm.go(0, 2'h1, 32'hA55F_0002, 0, q, e, c);
      cmp("half", 32'h0000_33AB, q);
      lm.go(0, 2'h2, 32'hA55F_0000, 0, q, e, c);
      cmp("word", 32'h1122_33AB, q);
      cmp("local cycles", 1, 32'(c));
   endtask
   task t_sys;
      sm.go(1, 2'h2, 32'h0560_FFFC, 32'hDEAD_BEEF, q, e, c);
      cmp("sys cycles", 2, 32'(c));
      lm.go(0, 2'h2, 32'hA560_FFFC, 0, q, e, c);
      cmp("shared word", 32'hDEAD_BEEF, q);
      sm.go(0, 2'h2, 32'h055F_0000, 0, q, e, c);
      cmp("sys read", 32'h1122_33AB, q);
      cmp("sys good error", 0, {31'h0, e});
      sm.go(0, 2'h0, 32'h055F_0003, 0, q, e, c);
      cmp("sys byte", 32'h0000_00AB, q);
   endtask
   task t_clash;
      fork
         sm.go(1, 2'h2, 32'h055F_0010, 32'hCAFE_0001, q2, e2, c2);
         lm.go(0, 2'h2, 32'hA55F_0010, 0, q, e, c);
      join
      cmp("after clash", 32'hCAFE_0001, q);
      cmp("stall cycles", 3, 32'(c));
      fork
         sm.go(1, 2'h2, 32'h0560_0000, 32'h0000_0005, q2, e2, c2);
         lm.go(0, 2'h2, 32'hA55F_0010, 0, q, e, c);
      join
      cmp("other page", 1, 32'(c));
   endtask
   task t_refuse;
      lm.go(1, 2'h2, 32'hA55F_0030, 32'h1234_5678, q, e, c);
      sleepMode <= 1'b1;
      sm.go(1, 2'h2, 32'h055F_0030, 32'h0000_0000, q, e, c);
      cmp("sleep error", 1, {31'h0, e});
      sleepMode <= 1'b0;
      lm.go(1, 2'h2, 32'h055F_0030, 32'h0000_0000, q, e, c);
      cmp("cached local error", 1, {31'h0, e});
      sm.go(1, 2'h2, 32'h0561_0000, 32'h0000_0000, q, e, c);
      cmp("window error", 1, {31'h0, e});
      lm.go(0, 2'h1, 32'hA55F_0031, 0, q, e, c);
      cmp("misaligned error", 1, {31'h0, e});
      lm.go(0, 2'h2, 32'hA55F_0030, 0, q, e, c);
      cmp("kept word", 32'h1234_5678, q);
   endtask
   initial begin
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      t_sizes;
      t_sys;
      t_clash;
      t_refuse;
      stop_test;
   end
   initial begin
      repeat (2000) @(posedge clock);
      n_fail++;
      stop_test;
   end
endmodule
`default_nettype wire
